// ==== shared/cfi_pkg.sv ====
package cfi_pkg;
  ////////////////////////////////////////////////////////////////
  // widths and command bit positions
  localparam int CMD_W  = 8;
  localparam int ID_W   = 8;
  localparam int ADDR_W = 5;
  localparam int IRQ_W  = 4;
  localparam int TCNT_W = 10;

  localparam int CMD_WU = 0;
  localparam int CMD_WD = 1;
  localparam int CMD_BU = 2;
  localparam int CMD_BD = 3;
  localparam int CMD_EO = 4;
  localparam int CMD_EI = 5;
  localparam int CMD_RCW  = 6;
  localparam int CMD_RCCW = 7;

  ////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS         = 1;
  localparam int BOOM_DELAY_MS   = 1000;
  localparam int LED_LINK_MS     = 500;
  localparam int LED_IDLE_MS     = 1000;
  localparam int LINK_TIMEOUT_MS = 250;
  localparam logic [TCNT_W-1:0] BOOM_DELAY_TICKS   = TCNT_W'(BOOM_DELAY_MS / TICK_MS);
  localparam logic [TCNT_W-1:0] LED_LINK_TICKS     = TCNT_W'(LED_LINK_MS / TICK_MS);
  localparam logic [TCNT_W-1:0] LED_IDLE_TICKS     = TCNT_W'(LED_IDLE_MS / TICK_MS);
  localparam logic [TCNT_W-1:0] LINK_TIMEOUT_TICKS = TCNT_W'(LINK_TIMEOUT_MS / TICK_MS);

  ////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_TX_ID    = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUTS  = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h14;

  localparam int CTRL_ON_BOOM = 0;
  localparam int CTRL_WL_EN   = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [ID_W-1:0] TX_ID_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam int IRQ_OVERLOAD  = 0;
  localparam int IRQ_TWO_BLOCK = 1;
  localparam int IRQ_LINK_LOST = 2;
  localparam int IRQ_FOREIGN   = 3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cfi_bus_e;
endpackage : cfi_pkg

// ==== core/cfi_sync.sv ====
module cfi_sync #(
  parameter int W = 1
) (
  input  logic         core_clk,
  input  logic         rst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  import cfi_pkg::*;

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit only moves once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          q[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : cfi_sync

// ==== core/cfi_tick.sv ====
module cfi_tick #(
  parameter int DIV = 2
) (
  input  logic core_clk,
  input  logic rst,
  output logic tick
);
  import cfi_pkg::*;

  logic [31:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick    <= 1'b0;
    end
  end
endmodule : cfi_tick

// ==== core/cfi_top.sv ====
// Operation
// - overload or two-block blocks the winch-up and extend-out outputs at once; boom-down as below.
// - winch down, boom up, extend in and rotation still pass during a trip.
// - closed load-pressure contact is healthy, open contact is overload.
// - closed two-block contact is healthy, open contact is a two-block condition.
// - either safety input unhealthy inhibits winch up and extend out; boom down follows the rules below.
// - with the winch on the boom a two-block trip leaves boom down alone but blocks winch up and extend out.
// - a load-sensor trip removes boom down only after one second.
// - a wireless command drives the outputs exactly as the same pendant command would.
// - wireless frames with a foreign transmitter identity are ignored.
// - the green indicator toggles every half second with link and every second without.
// - the pump solenoid is on whenever any function output is driven.
// - the up-limit switch stops boom up.
module cfi_top #(
  parameter int TICK_CYCLES = cfi_pkg::TICK_CYCLES
) (
  input  logic                       core_clk,
  input  logic                       rst,
  input  logic [cfi_pkg::ADDR_W-1:0] avs_address,
  input  logic                       avs_read,
  input  logic                       avs_write,
  input  logic [31:0]                avs_writedata,
  input  logic [3:0]                 avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  logic [cfi_pkg::CMD_W-1:0]  pendant_cmd,
  input  logic                       rx_strobe,
  input  logic [cfi_pkg::ID_W-1:0]   rx_id,
  input  logic [cfi_pkg::CMD_W-1:0]  rx_cmd,
  input  logic                       load_sensor_ok,
  input  logic                       two_block_switch,
  input  logic                       up_limit,
  output logic [cfi_pkg::CMD_W-1:0]  func_out,
  output logic                       pump_out,
  output logic                       status_led,
  output logic                       irq
);
  import cfi_pkg::*;

  localparam int SYNC_W = 2 * CMD_W + ID_W + 4;

  logic [SYNC_W-1:0]   pin_raw;
  logic [SYNC_W-1:0]   pin_s;
  logic [CMD_W-1:0]    pend_s;
  logic                strobe_s;
  logic [ID_W-1:0]     id_s;
  logic [CMD_W-1:0]    rxc_s;
  logic                load_ok;
  logic                tb_ok;
  logic                uplim;
  logic                tick;
  logic                overload;
  logic                two_block;
  logic [1:0]          ctrl_reg;
  logic [ID_W-1:0]     tx_id_reg;
  logic [IRQ_W-1:0]    irq_st_reg;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic [IRQ_W-1:0]    irq_ev;
  logic [IRQ_W-1:0]    irq_clr;
  cfi_bus_e            bus_state_reg;
  logic [31:0]         rd_next;
  logic                wr_take;
  logic                strobe_prev_reg;
  logic                rx_take;
  logic                id_match;
  logic [TCNT_W-1:0]   link_cnt_reg;
  logic                link_active;
  logic [CMD_W-1:0]    rx_cmd_reg;
  logic [TCNT_W-1:0]   bd_cnt_reg;
  logic                bd_inh_reg;
  logic                ovl_prev_reg;
  logic                tb_prev_reg;
  logic [CMD_W-1:0]    cmd_all;
  logic [CMD_W-1:0]    func_next;
  logic [TCNT_W-1:0]   led_cnt_reg;
  logic [TCNT_W-1:0]   led_int;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers and time base
  assign pin_raw = {up_limit, two_block_switch, load_sensor_ok, rx_cmd, rx_id, rx_strobe, pendant_cmd};

  cfi_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (pin_raw),
    .q        (pin_s)
  );

  cfi_tick #(.DIV(TICK_CYCLES)) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  assign pend_s   = pin_s[CMD_W-1:0];
  assign strobe_s = pin_s[CMD_W];
  assign id_s     = pin_s[CMD_W+ID_W:CMD_W+1];
  assign rxc_s    = pin_s[2*CMD_W+ID_W:CMD_W+ID_W+1];
  assign load_ok  = pin_s[SYNC_W-3];
  assign tb_ok    = pin_s[SYNC_W-2];
  assign uplim    = pin_s[SYNC_W-1];

  // open contact means trip; synced value resets low so power-up is tripped
  assign overload  = ~load_ok;
  assign two_block = ~tb_ok;

  ////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then a single answer cycle
  assign wr_take = (bus_state_reg == BUS_ACK) && avs_write;

  always_comb begin
    rd_next = 32'h00000000;
    case (avs_address)
      ADDR_CTRL:     rd_next = {30'h00000000, ctrl_reg};
      ADDR_TX_ID:    rd_next = {24'h000000, tx_id_reg};
      ADDR_STATUS:   rd_next = {26'h0000000, bd_inh_reg, overload | two_block, link_active, uplim, tb_ok, load_ok};
      ADDR_OUTPUTS:  rd_next = {23'h000000, pump_out, func_out};
      ADDR_IRQ_STAT: rd_next = {28'h0000000, irq_st_reg};
      ADDR_IRQ_MASK: rd_next = {28'h0000000, irq_mask_reg};
      default:       rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_state_reg   <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg   <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_next : 32'h00000000;
          end
        end
        BUS_ACK: begin
          bus_state_reg   <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_reg   <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // all writable fields sit in byte lane 0; only the pump readback bit lies above it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg     <= CTRL_RST;
      tx_id_reg    <= TX_ID_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_take && avs_byteenable[0]) begin
      case (avs_address)
        ADDR_CTRL:     ctrl_reg     <= avs_writedata[1:0];
        ADDR_TX_ID:    tx_id_reg    <= avs_writedata[ID_W-1:0];
        ADDR_IRQ_MASK: irq_mask_reg <= avs_writedata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // wireless receiver
  // data pins pass the same synchroniser as the strobe, so the
  // transmitter must hold id and command steady around the strobe edge
  assign rx_take  = strobe_s & ~strobe_prev_reg;
  assign id_match = (id_s == tx_id_reg);
  assign link_active = (link_cnt_reg != '0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_prev_reg <= 1'b0;
      link_cnt_reg    <= '0;
      rx_cmd_reg      <= '0;
    end else begin
      strobe_prev_reg <= strobe_s;
      if (rx_take && id_match) begin
        link_cnt_reg <= LINK_TIMEOUT_TICKS;
        rx_cmd_reg   <= rxc_s;
      end else begin
        if (tick && link_active) begin
          link_cnt_reg <= link_cnt_reg - TCNT_W'(1);
        end
        // a silent transmitter must not leave a function running
        if (!link_active) begin
          rx_cmd_reg <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // boom-down delay after a load-sensor trip
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bd_cnt_reg <= '0;
      bd_inh_reg <= 1'b0;
    end else if (!overload) begin
      bd_cnt_reg <= '0;
      bd_inh_reg <= 1'b0;
    end else if (tick && !bd_inh_reg) begin
      if (bd_cnt_reg == BOOM_DELAY_TICKS - TCNT_W'(1)) begin
        bd_inh_reg <= 1'b1;
      end else begin
        bd_cnt_reg <= bd_cnt_reg + TCNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // function outputs
  // wireless commands merge into the same path as the pendant
  assign cmd_all = pend_s | (ctrl_reg[CTRL_WL_EN] ? rx_cmd_reg : '0);

  always_comb begin
    func_next = cmd_all;
    if (overload || two_block) begin
      func_next[CMD_WU] = 1'b0;
      func_next[CMD_EO] = 1'b0;
    end
    if (bd_inh_reg || (two_block && !ctrl_reg[CTRL_ON_BOOM])) begin
      func_next[CMD_BD] = 1'b0;
    end
    if (uplim) begin
      func_next[CMD_BU] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      func_out <= '0;
      pump_out <= 1'b0;
    end else begin
      func_out <= func_next;
      pump_out <= |func_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // link indicator
  assign led_int = link_active ? LED_LINK_TICKS : LED_IDLE_TICKS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      led_cnt_reg <= '0;
      status_led  <= 1'b0;
    end else if (tick) begin
      // >= so a shorter interval after link-up takes effect at once
      if (led_cnt_reg >= led_int - TCNT_W'(1)) begin
        led_cnt_reg <= '0;
        status_led  <= ~status_led;
      end else begin
        led_cnt_reg <= led_cnt_reg + TCNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupts: sticky events, write one to clear, set beats clear
  assign irq_ev[IRQ_OVERLOAD]  = overload & ~ovl_prev_reg;
  assign irq_ev[IRQ_TWO_BLOCK] = two_block & ~tb_prev_reg;
  assign irq_ev[IRQ_LINK_LOST] = tick && (link_cnt_reg == TCNT_W'(1)) && !(rx_take && id_match);
  assign irq_ev[IRQ_FOREIGN]   = rx_take & ~id_match;
  assign irq_clr = (wr_take && avs_byteenable[0] && avs_address == ADDR_IRQ_STAT) ?
                   avs_writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // synced contacts read tripped after reset, so no false event at release
      ovl_prev_reg <= 1'b1;
      tb_prev_reg  <= 1'b1;
      irq_st_reg   <= '0;
      irq          <= 1'b0;
    end else begin
      ovl_prev_reg <= overload;
      tb_prev_reg  <= two_block;
      irq_st_reg   <= (irq_st_reg & ~irq_clr) | irq_ev;
      irq          <= |(irq_st_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  localparam int BD_LAST = int'(BOOM_DELAY_TICKS) - 1;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_damaging_block: assert property (
    (overload || two_block) |=> (!func_out[CMD_WU] && !func_out[CMD_EO]))
    else $error("winch up or extend out driven during a trip");

  chk_safe_dirs_pass: assert property (
    (cmd_all[CMD_WD] && cmd_all[CMD_EI] && cmd_all[CMD_RCW]) |=>
      (func_out[CMD_WD] && func_out[CMD_EI] && func_out[CMD_RCW] && pump_out))
    else $error("safe direction not passed");

  chk_bd_delay_end: assert property (
    $rose(bd_inh_reg) |-> ($past(bd_cnt_reg) == TCNT_W'(BD_LAST) && $past(tick) && $past(overload)))
    else $error("boom down inhibit rose before the delay ran out");

  chk_bd_cancel: assert property (
    !overload |=> (bd_cnt_reg == '0 && !bd_inh_reg))
    else $error("delay not cancelled on reclose");

  chk_on_boom_bd: assert property (
    (two_block && ctrl_reg[CTRL_ON_BOOM] && !bd_inh_reg && cmd_all[CMD_BD]) |=>
      func_out[CMD_BD] ##0 !func_out[CMD_WU])
    else $error("winch on boom: boom down wrongly removed");

  chk_bd_two_block: assert property (
    (two_block && !ctrl_reg[CTRL_ON_BOOM]) |=> !func_out[CMD_BD])
    else $error("boom down driven with two-block open");

  chk_pump_follow: assert property (
    pump_out == (|func_out))
    else $error("pump does not match function outputs");

  chk_up_limit_stop: assert property (
    uplim |=> !func_out[CMD_BU])
    else $error("boom up driven at up limit");

  chk_foreign_ignored: assert property (
    (rx_take && !id_match && link_active) |=> (rx_cmd_reg == $past(rx_cmd_reg)))
    else $error("foreign frame changed the command");

  chk_wireless_drive: assert property (
    (rx_take && id_match && ctrl_reg[CTRL_WL_EN] && rxc_s[CMD_WD]) |=> ##1 func_out[CMD_WD])
    else $error("wireless command not driven");

  chk_led_rate: assert property (
    $changed(status_led) |-> ($past(tick) && $past(led_cnt_reg) >= $past(led_int) - TCNT_W'(1)))
    else $error("indicator toggled off schedule");

  chk_irq_level: assert property (
    (|(irq_st_reg & irq_mask_reg)) |=> irq)
    else $error("interrupt not raised");

  cov_bd_inhibit: cover property (overload ##1 $rose(bd_inh_reg));
  cov_reclose:    cover property (overload && bd_cnt_reg != '0 ##1 !overload);
  cov_link_up:    cover property ($rose(link_active));
  cov_foreign:    cover property (irq_ev[IRQ_FOREIGN]);
endmodule : cfi_top

// ==== dv/cfi_partner.sv ====
module cfi_partner (
  input  logic                      core_clk,
  output logic                      rx_strobe,
  output logic [cfi_pkg::ID_W-1:0]  rx_id,
  output logic [cfi_pkg::CMD_W-1:0] rx_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfi_pkg::*;

  initial begin
    rx_strobe = 1'b0;
    rx_id     = 8'h00;
    rx_cmd    = 8'h00;
  end

  // id and command held well around the strobe, the receiver syncs all three
  task automatic frame(input logic [ID_W-1:0] id, input logic [CMD_W-1:0] c);
    @(posedge core_clk);
    rx_id  <= id;
    rx_cmd <= c;
    repeat (6) @(posedge core_clk);
    rx_strobe <= 1'b1;
    repeat (6) @(posedge core_clk);
    rx_strobe <= 1'b0;
    repeat (6) @(posedge core_clk);
    // released lines show the inverse so stale data cannot pass as valid
    rx_id  <= ~id;
    rx_cmd <= ~c;
  endtask : frame
endmodule : cfi_partner

// ==== dv/crane_function_interlock_test.sv ====
module crane_function_interlock_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cfi_pkg::*;

  localparam int TK = 4;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [CMD_W-1:0]  pendant_cmd;
  logic [CMD_W-1:0]  rx_cmd;
  logic [CMD_W-1:0]  func_out;
  logic [ID_W-1:0]   rx_id;
  logic              rx_strobe;
  logic              load_sensor_ok;
  logic              two_block_switch;
  logic              up_limit;
  logic              pump_out;
  logic              status_led;
  logic              irq;
  int                err_count;
  int                comparisons;
  logic [31:0]       rd;

  always #10 core_clk = ~core_clk;

  cfi_top #(.TICK_CYCLES(TK)) cfi_top_i (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pendant_cmd, .rx_strobe, .rx_id, .rx_cmd,
    .load_sensor_ok, .two_block_switch, .up_limit, .func_out, .pump_out, .status_led, .irq);
  cfi_partner cfi_partner_i (.core_clk, .rx_strobe, .rx_id, .rx_cmd);

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] e, input logic [31:0] a, input string m);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("BAD %0t %s exp %0h got %0h", $time, m, e, a);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    cmp(32'h1, {31'h0, n < 50}, "bus answer");
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic pins(input logic [7:0] c, input logic ls, input logic tb, input logic ul);
    @(posedge core_clk);
    pendant_cmd      <= c;
    load_sensor_ok   <= ls;
    two_block_switch <= tb;
    up_limit         <= ul;
  endtask : pins

  task automatic led_gap(output int n);
    logic s;
    s = status_led;
    n = 0;
    while (status_led === s && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : led_gap

  function automatic logic [7:0] exp_func(logic [7:0] c, logic ls, logic tb, logic ob, logic ul, logic dly);
    logic [7:0] r;
    r = c;
    if (!ls || !tb) begin
      r[CMD_WU] = 1'b0;
      r[CMD_EO] = 1'b0;
    end
    if ((!tb && !ob) || dly) begin
      r[CMD_BD] = 1'b0;
    end
    if (ul) begin
      r[CMD_BU] = 1'b0;
    end
    return r;
  endfunction : exp_func

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [7:0] c;
    logic [7:0] e;
    logic [7:0] tx;
    logic       ls;
    logic       tb;
    logic       ul;
    logic       ob;
    int         n;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {pendant_cmd, load_sensor_ok, two_block_switch, up_limit} = {8'h00, 1'b1, 1'b1, 1'b0};
    err_count   = 0;
    comparisons = 0;
    void'($urandom(32'hde2a));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    tick(10);
    bus(1'b0, ADDR_CTRL, 32'h0);
    cmp({30'h0, CTRL_RST}, rd, "ctrl reset");
    bus(1'b0, ADDR_TX_ID, 32'h0);
    cmp({24'h0, TX_ID_RST}, rd, "tx id reset");
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    cmp({28'h0, IRQ_MASK_RST}, rd, "mask reset");
    bus(1'b0, 5'h1C, 32'h0);
    cmp(32'h0, rd, "unmapped read");
    $display("test registers done");

    // random commands under random safety combinations, the four load-sensor-trip corners first
    for (int i = 0; i < 40; i++) begin
      c  = (i < 4) ? 8'hFF : 8'($urandom);
      {ls, tb, ob} = (i < 4) ? 3'(i) : 3'($urandom);
      ul = (i < 4) ? 1'b0 : 1'($urandom);
      bus(1'b1, ADDR_CTRL, {30'h0, 1'b1, ob});
      pins(c, ls, tb, ul);
      tick(8);
      e = exp_func(c, ls, tb, ob, ul, 1'b0);
      cmp({24'h0, e}, {24'h0, func_out}, "interlock");
      cmp({31'h0, |e}, {31'h0, pump_out}, "pump");
    end
    bus(1'b1, ADDR_CTRL, 32'h2);
    pins(8'hFF, 1'b1, 1'b1, 1'b0);
    tick(8);
    $display("test interlock done");

    // inhibit lands one edge after the synced trip, boom down waits the delay
    pins(8'hFF, 1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'h1, {31'h0, func_out[CMD_WU]}, "before inhibit");
    @(negedge core_clk);
    cmp(32'h0, {31'h0, func_out[CMD_WU]}, "inhibit edge");
    tick(1000 * TK - 20);
    cmp(32'h1, {31'h0, func_out[CMD_BD]}, "boom down early");
    tick(40);
    cmp({24'h0, exp_func(8'hFF, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1)}, {24'h0, func_out}, "boom down late");
    bus(1'b0, ADDR_STATUS, 32'h0);
    cmp(32'h00000032, rd, "status after delay");
    bus(1'b0, ADDR_OUTPUTS, 32'h0);
    cmp(32'h000001E6, rd, "outputs register");
    pins(8'hFF, 1'b1, 1'b1, 1'b0);
    tick(10);
    pins(8'hFF, 1'b0, 1'b1, 1'b0);
    tick(500 * TK);
    pins(8'hFF, 1'b1, 1'b1, 1'b0);
    tick(10);
    pins(8'hFF, 1'b0, 1'b1, 1'b0);
    tick(750 * TK);
    cmp(32'h1, {31'h0, func_out[CMD_BD]}, "delay restart");
    tick(300 * TK);
    cmp(32'h0, {31'h0, func_out[CMD_BD]}, "delay after restart");
    pins(8'h00, 1'b1, 1'b1, 1'b0);
    $display("test boom delay done");

    // wireless: own id drives outputs, foreign id only raises its event
    tx = 8'($urandom);
    c  = 8'($urandom);
    bus(1'b1, ADDR_TX_ID, {24'h0, tx});
    bus(1'b1, ADDR_IRQ_STAT, 32'hF);
    cfi_partner_i.frame(tx, c);
    tick(10);
    cmp({24'h0, c}, {24'h0, func_out}, "wireless");
    cfi_partner_i.frame(~tx, ~c);
    tick(10);
    cmp({24'h0, c}, {24'h0, func_out}, "foreign ignored");
    cmp(32'h0, {31'h0, irq}, "masked irq");
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    cmp(32'h1, {31'h0, rd[IRQ_FOREIGN]}, "foreign event");
    bus(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_FOREIGN);
    tick(3);
    cmp(32'h1, {31'h0, irq}, "irq raised");
    bus(1'b1, ADDR_IRQ_STAT, 32'h1 << IRQ_FOREIGN);
    tick(3);
    cmp(32'h0, {31'h0, irq}, "irq cleared");
    tick(300 * TK);
    cmp(32'h0, {24'h0, func_out}, "link lost clears");
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    cmp(32'h1, {31'h0, rd[IRQ_LINK_LOST]}, "link lost event");
    $display("test wireless done");

    // indicator: full period without link, half with frames kept coming
    led_gap(n);
    led_gap(n);
    cmp(32'h1, {31'h0, n >= 1000 * TK - 8 && n <= 1000 * TK + 8}, "led idle");
    fork
      repeat (18) begin
        cfi_partner_i.frame(tx, 8'h00);
        tick(120 * TK);
      end
    join_none
    led_gap(n);
    led_gap(n);
    led_gap(n);
    cmp(32'h1, {31'h0, n >= 500 * TK - 8 && n <= 500 * TK + 8}, "led linked");
    $display("test indicator done");
    tally_and_finish();
  end
endmodule : crane_function_interlock_test
